// ===== rtl/lpdi_params.svh
`ifndef LPDI_PARAMS_SVH
`define LPDI_PARAMS_SVH

// register offsets (5-bit host address)
`define LPDI_ADDR_W          5
`define LPDI_OFS_SEG7        5'h0e
`define LPDI_OFS_SEG8        5'h0f
`define LPDI_OFS_CTRL        5'h10

// reset values
`define LPDI_RST_SEG7        8'h00
`define LPDI_RST_SEG8        8'h00
`define LPDI_RST_CTRL        8'h00

// segment register fields
`define LPDI_SEG_SIGN_BIT    6
`define LPDI_SEG_MSB         6
`define LPDI_SEG_LSB         0
`define LPDI_SEG_COUNT       8

// control register fields
`define LPDI_CTRL_RAIL_BIT   7
`define LPDI_CTRL_AONES_BIT  6
`define LPDI_CTRL_RXEDGE_BIT 5
`define LPDI_CTRL_TXEDGE_BIT 4
`define LPDI_CTRL_POL_BIT    3
`define LPDI_CTRL_SRST_BIT   0

// timing
`define LPDI_CLK_MHZ         100
`define LPDI_SRST_US         10
`define LPDI_SRST_CYC        (`LPDI_SRST_US * `LPDI_CLK_MHZ)

`endif

// ===== rtl/lpdi_pkg.sv
package lpdi_pkg;

  typedef enum logic [1:0] {
    LPDI_SR_IDLE = 2'b00,
    LPDI_SR_WAIT = 2'b01,
    LPDI_SR_FIRE = 2'b10
  } lpdi_srst_state_t;

  typedef logic [7:0] lpdi_reg_t;

endpackage

// ===== rtl/lpdi_edge_det.sv
`timescale 1ns/1ps
module lpdi_edge_det #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  // sampled level
  input  wire logic [W-1:0] level,
  // edge pulses
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);

  logic [W-1:0] prev_r;
  logic [W-1:0] prev_nxt;

  always_comb begin
    prev_nxt = level;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      prev_r <= '0;
    end else begin
      prev_r <= prev_nxt;
    end
  end

  assign rise = level & ~prev_r;
  assign fall = ~level & prev_r;

endmodule

// ===== rtl/lpdi_cfg.sv
`timescale 1ns/1ps
// Summary of operation
// R1: segment amplitudes used only in arbitrary mode
// R2: pulse split into eight equal segments
// R3: seventh segment amplitude, signed magnitude, bits 6-0
// R4: eighth segment amplitude, signed magnitude, bits 6-0
// R5: bit 7 one single rail, zero dual
// R6: bit 6 sends all ones on signal loss
// R7: bit 5 picks receive output update edge
// R8: bit 4 picks transmit sampling edge
// R9: framer changes data on opposite edge
// R10: bit 3 selects active high or low data
// R11: bit 0 held over 10us resets state
// R12: all bits read/write, reset to zero
// R13: soft reset bit does not self-clear
`include "lpdi_params.svh"
module lpdi_cfg
  import lpdi_pkg::*;
(
  // clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    resetn,
  // host register port
  input  wire logic [`LPDI_ADDR_W-1:0] reg_addr,
  input  wire logic                    reg_wr_en,
  input  wire logic [7:0]              reg_wr_data,
  input  wire logic                    reg_rd_en,
  output logic      [7:0]              reg_rd_data,
  // pulse shaper timing
  input  wire logic                    arb_pulse_mode,
  input  wire logic                    pulse_start,
  input  wire logic                    seg_tick,
  output logic      [2:0]              seg_index,
  output logic                         seg_active,
  output logic                         seg_amp_valid,
  output logic      [6:0]              seg_amplitude,
  // system transmit pins
  input  wire logic                    xmit_input_clock,
  input  wire logic                    xmit_positive_or_data_in,
  input  wire logic                    xmit_negative_in,
  input  wire logic                    recv_signal_loss,
  output logic                         tx_pos,
  output logic                         tx_neg,
  output logic                         tx_strobe,
  output logic                         tx_all_ones,
  // system receive pins
  input  wire logic                    recv_clock,
  input  wire logic                    recv_pos_in,
  input  wire logic                    recv_neg_in,
  output logic                         recv_pos_out,
  output logic                         recv_neg_out,
  // control state
  output logic                         rail_format_select,
  output logic                         soft_state_reset
);

  localparam logic [10:0] SRST_CYC = 11'(`LPDI_SRST_CYC);

  // registers
  lpdi_reg_t seg7_r, seg7_nxt;
  lpdi_reg_t seg8_r, seg8_nxt;
  lpdi_reg_t ctrl_r, ctrl_nxt;
  lpdi_reg_t rd_r, rd_nxt;

  logic auto_ones_on_signal_loss;
  logic recv_output_edge_select;
  logic xmit_sample_edge_select;
  logic data_polarity_select;
  logic [6:0] seg7_amplitude;
  logic [6:0] seg8_amplitude;

  assign seg7_amplitude           = seg7_r[`LPDI_SEG_MSB:`LPDI_SEG_LSB]; // see R3
  assign seg8_amplitude           = seg8_r[`LPDI_SEG_MSB:`LPDI_SEG_LSB]; // see R4
  assign rail_format_select       = ctrl_r[`LPDI_CTRL_RAIL_BIT];
  assign auto_ones_on_signal_loss = ctrl_r[`LPDI_CTRL_AONES_BIT];
  assign recv_output_edge_select  = ctrl_r[`LPDI_CTRL_RXEDGE_BIT];
  assign xmit_sample_edge_select  = ctrl_r[`LPDI_CTRL_TXEDGE_BIT];
  assign data_polarity_select     = ctrl_r[`LPDI_CTRL_POL_BIT];

  always_comb begin
    seg7_nxt = seg7_r;
    seg8_nxt = seg8_r;
    ctrl_nxt = ctrl_r;
    rd_nxt   = rd_r;
    if (reg_wr_en) begin
      // all eight bits stored, reserved ones too; bit 0 stays until rewritten
      case (reg_addr)
        `LPDI_OFS_SEG7: seg7_nxt = reg_wr_data; // see R12
        `LPDI_OFS_SEG8: seg8_nxt = reg_wr_data; // see R12
        `LPDI_OFS_CTRL: ctrl_nxt = reg_wr_data; // see R13
        default: ;
      endcase
    end
    if (reg_rd_en) begin
      case (reg_addr)
        `LPDI_OFS_SEG7: rd_nxt = seg7_r;
        `LPDI_OFS_SEG8: rd_nxt = seg8_r;
        `LPDI_OFS_CTRL: rd_nxt = ctrl_r;
        default:        rd_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      seg7_r <= `LPDI_RST_SEG7; // see R12
      seg8_r <= `LPDI_RST_SEG8;
      ctrl_r <= `LPDI_RST_CTRL;
      rd_r   <= 8'h00;
    end else begin
      seg7_r <= seg7_nxt;
      seg8_r <= seg8_nxt;
      ctrl_r <= ctrl_nxt;
      rd_r   <= rd_nxt;
    end
  end

  assign reg_rd_data = rd_r;

  // soft reset: fires only once the bit has been held past the interval
  lpdi_srst_state_t sr_state_r, sr_state_nxt;
  logic [10:0]      sr_cnt_r, sr_cnt_nxt;
  logic             srst_bit;

  assign srst_bit = ctrl_r[`LPDI_CTRL_SRST_BIT];

  always_comb begin
    sr_state_nxt = sr_state_r;
    sr_cnt_nxt   = sr_cnt_r;
    case (sr_state_r)
      LPDI_SR_IDLE: begin
        sr_cnt_nxt = 11'h000;
        if (srst_bit) begin
          sr_state_nxt = LPDI_SR_WAIT;
          sr_cnt_nxt   = 11'h001;
        end
      end
      LPDI_SR_WAIT: begin
        if (!srst_bit) begin
          sr_state_nxt = LPDI_SR_IDLE;
        end else if (sr_cnt_r == SRST_CYC) begin
          sr_state_nxt = LPDI_SR_FIRE; // see R11
        end else begin
          sr_cnt_nxt = sr_cnt_r + 11'h001;
        end
      end
      LPDI_SR_FIRE: begin
        if (!srst_bit) begin
          sr_state_nxt = LPDI_SR_IDLE; // see R13
        end
      end
      default: sr_state_nxt = LPDI_SR_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sr_state_r <= LPDI_SR_IDLE;
      sr_cnt_r   <= 11'h000;
    end else begin
      sr_state_r <= sr_state_nxt;
      sr_cnt_r   <= sr_cnt_nxt;
    end
  end

  assign soft_state_reset = (sr_state_r == LPDI_SR_FIRE); // see R11

  // arbitrary pulse segment sequencer
  logic [2:0] seg_idx_r, seg_idx_nxt;
  logic       seg_run_r, seg_run_nxt;
  logic       amp_vld_r, amp_vld_nxt;
  logic [6:0] amp_r, amp_nxt;

  always_comb begin
    seg_idx_nxt = seg_idx_r;
    seg_run_nxt = seg_run_r;
    if (soft_state_reset) begin
      seg_idx_nxt = 3'h0; // see R11
      seg_run_nxt = 1'b0;
    end else if (pulse_start) begin
      seg_idx_nxt = 3'h0;
      seg_run_nxt = 1'b1;
    end else if (seg_run_r && seg_tick) begin
      // eighth tick ends the master clock period
      if (seg_idx_r == 3'(`LPDI_SEG_COUNT - 1)) begin
        seg_run_nxt = 1'b0; // see R2
      end else begin
        seg_idx_nxt = seg_idx_r + 3'h1; // see R2
      end
    end
    amp_vld_nxt = 1'b0;
    amp_nxt     = 7'h00;
    // outside arbitrary mode the fixed shapes own the driver
    if (arb_pulse_mode && seg_run_nxt && !soft_state_reset) begin // see R1
      case (seg_idx_nxt)
        3'h6: begin
          amp_vld_nxt = 1'b1;
          amp_nxt     = seg7_amplitude; // see R3
        end
        3'h7: begin
          amp_vld_nxt = 1'b1;
          amp_nxt     = seg8_amplitude; // see R4
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      seg_idx_r <= 3'h0;
      seg_run_r <= 1'b0;
      amp_vld_r <= 1'b0;
      amp_r     <= 7'h00;
    end else begin
      seg_idx_r <= seg_idx_nxt;
      seg_run_r <= seg_run_nxt;
      amp_vld_r <= amp_vld_nxt;
      amp_r     <= amp_nxt;
    end
  end

  assign seg_index     = seg_idx_r;
  assign seg_active    = seg_run_r;
  assign seg_amp_valid = amp_vld_r;
  assign seg_amplitude = amp_r;

  // clock edge detection on the two system clocks
  logic [1:0] clk_rise;
  logic [1:0] clk_fall;

  lpdi_edge_det #(
    .W (2)
  ) u_edge (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .level   ({recv_clock, xmit_input_clock}),
    .rise    (clk_rise),
    .fall    (clk_fall)
  );

  // transmit sampling
  logic tx_pos_r, tx_pos_nxt;
  logic tx_neg_r, tx_neg_nxt;
  logic tx_stb_r, tx_stb_nxt;
  logic tx_ao_r, tx_ao_nxt;
  logic tx_take;
  logic ones_now;

  // relies on the framer changing data on the other edge
  assign tx_take  = xmit_sample_edge_select ? clk_rise[0] : clk_fall[0]; // see R8 R9
  assign ones_now = auto_ones_on_signal_loss && recv_signal_loss; // see R6

  always_comb begin
    tx_pos_nxt = tx_pos_r;
    tx_neg_nxt = tx_neg_r;
    tx_stb_nxt = 1'b0;
    tx_ao_nxt  = ones_now;
    if (soft_state_reset) begin
      tx_pos_nxt = 1'b0;
      tx_neg_nxt = 1'b0;
      tx_ao_nxt  = 1'b0;
    end else if (tx_take) begin
      tx_stb_nxt = 1'b1;
      if (ones_now) begin
        tx_pos_nxt = 1'b1; // see R6
        tx_neg_nxt = 1'b0;
      end else begin
        tx_pos_nxt = xmit_positive_or_data_in ^ data_polarity_select; // see R10
        // single rail ignores the negative pin
        tx_neg_nxt = rail_format_select ? 1'b0 :
                     (xmit_negative_in ^ data_polarity_select); // see R5
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tx_pos_r <= 1'b0;
      tx_neg_r <= 1'b0;
      tx_stb_r <= 1'b0;
      tx_ao_r  <= 1'b0;
    end else begin
      tx_pos_r <= tx_pos_nxt;
      tx_neg_r <= tx_neg_nxt;
      tx_stb_r <= tx_stb_nxt;
      tx_ao_r  <= tx_ao_nxt;
    end
  end

  assign tx_pos      = tx_pos_r;
  assign tx_neg      = tx_neg_r;
  assign tx_strobe   = tx_stb_r;
  assign tx_all_ones = tx_ao_r;

  // receive output update
  logic rx_pos_r, rx_pos_nxt;
  logic rx_neg_r, rx_neg_nxt;
  logic rx_upd;

  assign rx_upd = recv_output_edge_select ? clk_fall[1] : clk_rise[1]; // see R7

  always_comb begin
    rx_pos_nxt = rx_pos_r;
    rx_neg_nxt = rx_neg_r;
    if (soft_state_reset) begin
      rx_pos_nxt = data_polarity_select;
      rx_neg_nxt = data_polarity_select;
    end else if (rx_upd) begin
      rx_pos_nxt = recv_pos_in ^ data_polarity_select; // see R10
      rx_neg_nxt = rail_format_select ? data_polarity_select :
                   (recv_neg_in ^ data_polarity_select); // see R5
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rx_pos_r <= 1'b0;
      rx_neg_r <= 1'b0;
    end else begin
      rx_pos_r <= rx_pos_nxt;
      rx_neg_r <= rx_neg_nxt;
    end
  end

  assign recv_pos_out = rx_pos_r;
  assign recv_neg_out = rx_neg_r;

endmodule

// ===== testbench/lpdi_cfg_properties.sv
`timescale 1ns/1ps
`include "lpdi_params.svh"
module lpdi_cfg_properties
  import lpdi_pkg::*;
(
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       resetn,
  // host port
  input wire logic [4:0] reg_addr,
  input wire logic       reg_wr_en,
  input wire logic [7:0] reg_wr_data,
  input wire logic       reg_rd_en,
  input wire logic [7:0] reg_rd_data,
  // segments
  input wire logic       arb_pulse_mode,
  input wire logic       pulse_start,
  input wire logic       seg_tick,
  input wire logic [2:0] seg_index,
  input wire logic       seg_active,
  input wire logic       seg_amp_valid,
  input wire logic [6:0] seg_amplitude,
  // system pins
  input wire logic       xmit_input_clock,
  input wire logic       xmit_positive_or_data_in,
  input wire logic       recv_signal_loss,
  input wire logic       tx_pos,
  input wire logic       tx_neg,
  input wire logic       tx_strobe,
  input wire logic       tx_all_ones,
  input wire logic       recv_clock,
  input wire logic       recv_pos_in,
  input wire logic       recv_pos_out,
  // control state
  input wire logic       rail_format_select,
  input wire logic       soft_state_reset
);
  lpdi_reg_t   s7_r, s8_r, sc_r, exp_rd;
  logic [10:0] hcnt_r;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // copy kept from host writes alone, so a stuck register shows up
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s7_r <= '0;
      s8_r <= '0;
      sc_r <= '0;
      hcnt_r <= '0;
    end else begin
      if (reg_wr_en && reg_addr == `LPDI_OFS_SEG7) s7_r <= reg_wr_data;
      if (reg_wr_en && reg_addr == `LPDI_OFS_SEG8) s8_r <= reg_wr_data;
      if (reg_wr_en && reg_addr == `LPDI_OFS_CTRL) sc_r <= reg_wr_data;
      if (!sc_r[0]) hcnt_r <= '0;
      else if (hcnt_r != 11'h44c) hcnt_r <= hcnt_r + 11'h001;
    end
  end
  always_comb begin
    case (reg_addr)
      `LPDI_OFS_SEG7: exp_rd = s7_r;
      `LPDI_OFS_SEG8: exp_rd = s8_r;
      `LPDI_OFS_CTRL: exp_rd = sc_r;
      default: exp_rd = 8'h00;
    endcase
  end
  sequence s_launch;
    pulse_start && !soft_state_reset;
  endsequence
  sequence s_first;
    seg_active && seg_index == 3'h0;
  endsequence
  property p_rd_value;
    reg_rd_en |=> reg_rd_data == $past(exp_rd);
  endproperty
  property p_rd_hold;
    !reg_rd_en |=> $stable(reg_rd_data);
  endproperty
  property p_rail;
    rail_format_select == sc_r[7];
  endproperty
  property p_aones;
    !soft_state_reset && !$past(soft_state_reset) |->
      tx_all_ones == ($past(sc_r[6]) & $past(recv_signal_loss));
  endproperty
  property p_start;
    s_launch |=> s_first;
  endproperty
  property p_step;
    seg_tick && !pulse_start && seg_active && !soft_state_reset |=>
      (seg_active ? seg_index == $past(seg_index) + 3'h1 : $past(seg_index) == 3'h7);
  endproperty
  property p_amp;
    seg_amp_valid |-> seg_active && seg_index[2:1] == 2'b11 &&
      seg_amplitude == (seg_index[0] ? $past(s8_r[6:0]) : $past(s7_r[6:0]));
  endproperty
  property p_arb_off;
    !arb_pulse_mode && !$past(arb_pulse_mode) |-> !seg_amp_valid;
  endproperty
  property p_srst;
    soft_state_reset == (hcnt_r > 11'(`LPDI_SRST_CYC));
  endproperty
  property p_tx;
    (sc_r[4] ? $rose(xmit_input_clock) : $fell(xmit_input_clock)) && !sc_r[6] &&
      !soft_state_reset |-> ##[1:3] (tx_strobe && (!sc_r[7] || !tx_neg) &&
      tx_pos == (xmit_positive_or_data_in ^ sc_r[3]));
  endproperty
  property p_rx;
    (sc_r[5] ? $fell(recv_clock) : $rose(recv_clock)) && !soft_state_reset |->
      ##[1:3] recv_pos_out == (recv_pos_in ^ sc_r[3]);
  endproperty
  a_rd_value: assert property (p_rd_value) else $error("read data wrong");
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  a_rail: assert property (p_rail) else $error("rail select wrong");
  a_aones: assert property (p_aones) else $error("all ones wrong");
  a_start: assert property (p_start) else $error("pulse start wrong");
  a_step: assert property (p_step) else $error("segment step wrong");
  a_amp: assert property (p_amp) else $error("amplitude wrong");
  a_arb_off: assert property (p_arb_off) else $error("amplitude outside mode");
  a_srst: assert property (p_srst) else $error("soft reset timing wrong");
  a_tx: assert property (p_tx) else $error("transmit sample wrong");
  a_rx: assert property (p_rx) else $error("receive update wrong");
endmodule
bind lpdi_cfg lpdi_cfg_properties u_props (.*);

// ===== testbench/lpdi_framer_model.sv
`timescale 1ns/1ps
module lpdi_framer_model (
  // system clock
  input  wire logic clk_sys,
  // pattern request
  input  wire logic run,
  input  wire logic rise_smp,
  input  wire logic pos_val,
  input  wire logic neg_val,
  // framer pins
  output logic      xclk,
  output logic      xpos,
  output logic      xneg
);
  logic [2:0] cnt_r;
  initial begin
    xclk = 1'b0;
    xpos = 1'b0;
    xneg = 1'b0;
    cnt_r = 3'h0;
  end
  // clock stands still between frames
  always @(posedge clk_sys) begin
    if (run) cnt_r <= cnt_r + 3'h1;
    if (run && cnt_r == 3'h7) xclk <= #1 !xclk;
    if (run && cnt_r == 3'h7 && xclk == rise_smp) begin
      xpos <= #1 pos_val;
      xneg <= #1 neg_val;
    end
  end
endmodule

// ===== testbench/tb_lpdi_cfg.sv
`timescale 1ns/1ps
`include "lpdi_params.svh"
module tb_lpdi_cfg
  import lpdi_pkg::*;
;
  logic [4:0] reg_addr;
  logic [4:0] ofs [3] = '{`LPDI_OFS_SEG7, `LPDI_OFS_SEG8, `LPDI_OFS_CTRL};
  lpdi_reg_t  pat [3] = '{8'hc5, 8'hba, 8'h86};
  lpdi_reg_t  reg_wr_data, reg_rd_data;
  logic [2:0] seg_index;
  logic [6:0] seg_amplitude;
  logic       clk_sys, resetn, reg_wr_en, reg_rd_en, arb_pulse_mode, pulse_start, seg_tick;
  logic       seg_active, seg_amp_valid, xmit_input_clock, xmit_positive_or_data_in;
  logic       xmit_negative_in, recv_signal_loss, tx_pos, tx_neg, tx_strobe, tx_all_ones;
  logic       recv_clock, recv_pos_in, recv_neg_in, recv_pos_out, recv_neg_out;
  logic       rail_format_select, soft_state_reset, run, rise_smp, pos_val;
  int         bad_count, checks_done, cyc;
  lpdi_cfg u_dut (.*);
  lpdi_framer_model u_frm (.clk_sys(clk_sys), .run(run), .rise_smp(rise_smp),
    .pos_val(pos_val), .neg_val(pos_val), .xclk(xmit_input_clock),
    .xpos(xmit_positive_or_data_in), .xneg(xmit_negative_in));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // receive clock runs only with the framer so control writes never straddle an edge
  always begin
    repeat (4) @(posedge clk_sys);
    if (run) recv_clock <= #1 ~recv_clock;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  task automatic step(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic blip(ref logic s);
    step(1);
    s = 1'b1;
    step(1);
    s = 1'b0;
  endtask
  task automatic wr(logic [4:0] a, lpdi_reg_t d);
    step(1);
    reg_addr = a;
    reg_wr_data = d;
    reg_wr_en = 1'b1;
    step(1);
    reg_wr_en = 1'b0;
  endtask
  task automatic rd(logic [4:0] a, lpdi_reg_t e);
    step(1);
    reg_addr = a;
    reg_rd_en = 1'b1;
    step(1);
    reg_rd_en = 1'b0;
    chk("reg_rd_data", e, reg_rd_data);
  endtask
  task automatic wait_strobe();
    int n;
    n = 0;
    step(1);
    while (tx_strobe !== 1'b1 && n < 100) begin
      step(1);
      n++;
    end
    chk("tx_strobe", 8'h01, tx_strobe);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    {reg_wr_en, reg_rd_en, arb_pulse_mode, pulse_start, seg_tick, recv_signal_loss} = '0;
    {reg_addr, reg_wr_data, recv_clock, recv_pos_in, recv_neg_in, run, rise_smp} = '0;
    {pos_val, resetn, bad_count, checks_done, cyc} = '0;
    step(6);
    resetn = 1'b1;
    foreach (ofs[i]) rd(ofs[i], 8'h00);
    foreach (ofs[i]) wr(ofs[i], pat[i]);
    wr(5'h11, 8'hff);
    foreach (ofs[i]) rd(ofs[i], pat[i]);
    rd(5'h11, 8'h00);
    chk("rail_format_select", 8'h01, rail_format_select);
    wr(`LPDI_OFS_CTRL, 8'h00);
    chk("rail_format_select", 8'h00, rail_format_select);
    for (int m = 1; m >= 0; m--) begin
      arb_pulse_mode = m[0];
      blip(pulse_start);
      chk("seg_active", 8'h01, seg_active);
      repeat (6) blip(seg_tick);
      chk("seg_amp_valid", m[0], seg_amp_valid);
      if (m == 1) chk("seg_amplitude", 8'h45, seg_amplitude);
      blip(seg_tick);
      if (m == 1) chk("seg_amplitude", 8'h3a, seg_amplitude);
      blip(seg_tick);
      chk("seg_active", 8'h00, seg_active);
    end
    wr(`LPDI_OFS_CTRL, 8'h40);
    recv_signal_loss = 1'b1;
    step(2);
    chk("tx_all_ones", 8'h01, tx_all_ones);
    wr(`LPDI_OFS_CTRL, 8'h00);
    step(2);
    chk("tx_all_ones", 8'h00, tx_all_ones);
    recv_signal_loss = 1'b0;
    pos_val = 1'b1;
    recv_pos_in = 1'b1;
    recv_neg_in = 1'b1;
    // single rail on the two middle passes, so the negative pin must be ignored there
    for (int k = 0; k < 4; k++) begin
      run = 1'b0;
      wr(`LPDI_OFS_CTRL, {k[0] ^ k[1], 1'b0, k[1], k[1], k[0], 3'b000});
      rise_smp = k[1];
      run = 1'b1;
      repeat (2) wait_strobe();
      chk("xmit_input_clock", k[1], xmit_input_clock);
      chk("tx_pos", !k[0], tx_pos);
      chk("tx_neg", k == 0, tx_neg);
      chk("recv_pos_out", !k[0], recv_pos_out);
      chk("recv_neg_out", !k[1], recv_neg_out);
    end
    run = 1'b0;
    wr(`LPDI_OFS_CTRL, 8'h01);
    step(500);
    wr(`LPDI_OFS_CTRL, 8'h00);
    step(700);
    chk("soft_state_reset", 8'h00, soft_state_reset);
    wr(`LPDI_OFS_CTRL, 8'h01);
    step(1000);
    chk("soft_state_reset", 8'h00, soft_state_reset);
    step(1);
    chk("soft_state_reset", 8'h01, soft_state_reset);
    rd(`LPDI_OFS_CTRL, 8'h01);
    wr(`LPDI_OFS_CTRL, 8'h00);
    step(2);
    chk("soft_state_reset", 8'h00, soft_state_reset);
    tally_and_finish();
  end
endmodule
